// ===== rsc_ctrl.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module rsc_ctrl #(
  parameter int unsigned BLINK_CYC = rsc_pkg::BLINK_CYC,
  parameter int unsigned TEMP_CYC = rsc_pkg::TEMP_CYC
) (
  input logic clk,
  input logic rst_n,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic acquisition_pulse_input,
  input logic err_raise,
  input logic [rsc_pkg::ADC_W-1:0] adc_in,
  output rsc_pkg::rsc_amp_s amp_stage,
  output logic [7:0] agc_level_code,
  output logic [7:0] phase_code,
  output logic [7:0] qgain_code,
  output logic [7:0] offset_a,
  output logic [7:0] offset_b,
  output logic ctrl_shutdown,
  output logic osc_stop,
  output logic led_red,
  output logic led_green
);
  typedef struct packed {
    rsc_pkg::rsc_fsm_e fsm;
    rsc_pkg::rsc_set_s set;
    logic debug;
    logic [rsc_pkg::ERR_W-1:0] errs;
    logic [7:0] awaddr;
    logic aw_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_got;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [rsc_pkg::ADC_W-1:0] temp;
    logic temp_start;
    logic pulse_m;
    logic pulse_s;
    logic [rsc_pkg::BLINK_W-1:0] blink_cnt;
    logic blink;
    // busy cycles of the converter, so its end can be bounded without a long delay range
    logic [15:0] tw_cnt;
  } rsc_ctrl_s;

  rsc_ctrl_s s_q;
  rsc_ctrl_s s_d;
  rsc_pkg::rsc_set_s dflt_set;
  logic [rsc_pkg::GT_ENT_W-1:0] tbl_ent;
  logic [rsc_pkg::GT_IDX_W-1:0] tbl_rd_idx;
  logic save_en;
  logic tbl_we;
  logic temp_busy;
  logic temp_done;
  logic [rsc_pkg::ADC_W-1:0] temp_val;
  logic shutdown;
  logic wr_fire;
  logic [32:0] cur;
  logic [32:0] rd;
  logic [31:0] wv;
  logic [31:0] gain_wv;
  logic [3:0] opc;
  logic is_del;
  logic del;
  logic raise_bad;
  logic amp_wr_ok;
  logic gain_wr_ok;
  logic inc_qg;
  logic [rsc_pkg::ERR_W:0] e_sum;

  // =====================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // saturating one-code step of an 8-bit converter
  function automatic logic [7:0] step8(input logic [7:0] v, input logic up);
    logic [7:0] r;
    r = v;
    if (up && v != 8'hFF) r = v + 8'h01;
    if (!up && v != 8'h00) r = v - 8'h01;
    return r;
  endfunction : step8

  function automatic logic [32:0] reg_read(input logic [7:0] a, input rsc_ctrl_s s,
                                           input logic [rsc_pkg::GT_ENT_W-1:0] ent, input logic busy);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    if (a == rsc_pkg::OFF_CTRL) begin
      r[rsc_pkg::CTRL_DEBUG_BIT] = s.debug;
    end else if (a == rsc_pkg::OFF_CMD) begin
      r[31:0] = 32'h0000_0000;
    end else if (a == rsc_pkg::OFF_AMP) begin
      r[9:0] = s.set.amp;
    end else if (a == rsc_pkg::OFF_AGC) begin
      r[7:0] = s.set.agc;
    end else if (a == rsc_pkg::OFF_GAIN) begin
      r[15:0] = s.set.gain;
    end else if (a == rsc_pkg::OFF_PHASE) begin
      r[7:0] = s.set.phase;
    end else if (a == rsc_pkg::OFF_QGAIN) begin
      r[7:0] = s.set.qgain;
    end else if (a == rsc_pkg::OFF_OFFA) begin
      r[7:0] = s.set.offa;
    end else if (a == rsc_pkg::OFF_OFFB) begin
      r[7:0] = s.set.offb;
    end else if (a == rsc_pkg::OFF_STATUS) begin
      r[rsc_pkg::ERR_W-1:0] = s.errs;
      r[rsc_pkg::ST_DEBUG_BIT] = s.debug;
      r[rsc_pkg::ST_BUSY_BIT] = busy;
      r[rsc_pkg::ST_HALT_BIT] = (s.fsm == rsc_pkg::ST_HALT);
      r[rsc_pkg::ST_STEP_LSB +: rsc_pkg::GT_IDX_W] = rsc_pkg::gain_step(s.set.gain);
    end else if (a == rsc_pkg::OFF_TEMP) begin
      r[rsc_pkg::ADC_W-1:0] = s.temp;
    end else if (a == rsc_pkg::OFF_GTBL) begin
      r[rsc_pkg::GT_ENT_W-1:0] = ent;
    end else begin
      r[32] = 1'b0;
    end
    return r;
  endfunction : reg_read

  // =====================================================
  // storage and temperature converter
  rsc_nv_store #(.STEPS(rsc_pkg::GT_STEPS)) u_nv (
    .clk(clk),
    .save_en(save_en),
    .save_set(s_q.set),
    .tbl_we(tbl_we),
    .tbl_wr_idx(s_q.wdata[rsc_pkg::GT_IDX_LSB +: rsc_pkg::GT_IDX_W]),
    .tbl_wr_ent(s_q.wdata[rsc_pkg::GT_ENT_W-1:0]),
    .tbl_rd_idx(tbl_rd_idx),
    .dflt_set(dflt_set),
    .tbl_rd_ent(tbl_ent)
  );

  rsc_temp_conv #(.CONV_CYC(TEMP_CYC)) u_temp (
    .clk(clk),
    .rst_n(rst_n),
    .start(s_q.temp_start),
    .adc_in(adc_in),
    .busy(temp_busy),
    .done(temp_done),
    .value(temp_val)
  );

  // =====================================================
  // bus decode and command execution
  assign shutdown = s_q.pulse_s && !s_q.debug;
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign cur = reg_read(s_q.awaddr, s_q, tbl_ent, temp_busy);
  assign wv = merge(cur[31:0], s_q.wdata, s_q.wstrb);
  assign opc = s_q.wstrb[0] ? s_q.wdata[3:0] : rsc_pkg::CMD_NOP;
  assign is_del = (s_q.awaddr == rsc_pkg::OFF_CMD) && (opc == rsc_pkg::CMD_DEL_ERR);
  // gain write looks up the entry of the step it is about to select
  // built from the stored gain, not from cur, so the table lookup never feeds back into itself
  assign gain_wv = merge({16'h0000, s_q.set.gain}, s_q.wdata, s_q.wstrb);
  assign tbl_rd_idx = (wr_fire && s_q.awaddr == rsc_pkg::OFF_GAIN) ? rsc_pkg::gain_step(gain_wv[15:0])
                                                                   : rsc_pkg::gain_step(s_q.set.gain);

  always_comb begin
    s_d = s_q;
    save_en = 1'b0;
    tbl_we = 1'b0;
    del = 1'b0;
    raise_bad = 1'b0;
    amp_wr_ok = 1'b0;
    gain_wr_ok = 1'b0;
    inc_qg = 1'b0;
    rd = '0;
    s_d.temp_start = 1'b0;
    s_d.pulse_m = acquisition_pulse_input;
    s_d.pulse_s = s_q.pulse_m;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awaddr = s_axi_awaddr;
      s_d.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
      s_d.w_got = 1'b1;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd = reg_read(s_axi_araddr, s_q, tbl_ent, temp_busy);
      s_d.rvalid = 1'b1;
      s_d.rdata = rd[31:0];
      s_d.rresp = rd[32] ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_DECERR;
    end
    case (s_q.fsm)
      rsc_pkg::ST_BOOT: begin
        s_d.set = dflt_set;
        s_d.fsm = rsc_pkg::ST_RUN;
      end
      rsc_pkg::ST_RUN: begin
        if (shutdown) s_d.fsm = rsc_pkg::ST_HALT;
      end
      rsc_pkg::ST_HALT: begin
        // leaving a pulse reset behaves like power-up
        if (!shutdown) s_d.fsm = rsc_pkg::ST_BOOT;
      end
      default: begin
        s_d.fsm = rsc_pkg::ST_BOOT;
      end
    endcase
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = rsc_pkg::RESP_OKAY;
      if (!cur[32]) begin
        s_d.bresp = rsc_pkg::RESP_DECERR;
      end else if (s_q.fsm != rsc_pkg::ST_RUN || (s_q.errs != '0 && !is_del)) begin
        s_d.bresp = rsc_pkg::RESP_SLVERR;
      end else if (s_q.awaddr == rsc_pkg::OFF_CTRL) begin
        s_d.debug = wv[rsc_pkg::CTRL_DEBUG_BIT];
      end else if (s_q.awaddr == rsc_pkg::OFF_AMP) begin
        s_d.set.amp = rsc_pkg::rsc_amp_s'(wv[9:0]);
        amp_wr_ok = 1'b1;
      end else if (s_q.awaddr == rsc_pkg::OFF_AGC) begin
        s_d.set.agc = wv[7:0];
      end else if (s_q.awaddr == rsc_pkg::OFF_GAIN) begin
        if (wv[15:0] < rsc_pkg::GAIN_MIN || wv[15:0] > rsc_pkg::GAIN_MAX) begin
          s_d.bresp = rsc_pkg::RESP_SLVERR;
          raise_bad = 1'b1;
        end else begin
          s_d.set.gain = wv[15:0];
          s_d.set.amp = rsc_pkg::rsc_amp_s'(tbl_ent[rsc_pkg::GT_ENT_W-1:8]);
          s_d.set.agc = tbl_ent[7:0];
          gain_wr_ok = 1'b1;
        end
      end else if (s_q.awaddr == rsc_pkg::OFF_PHASE) begin
        s_d.set.phase = wv[7:0];
      end else if (s_q.awaddr == rsc_pkg::OFF_QGAIN) begin
        s_d.set.qgain = wv[7:0];
      end else if (s_q.awaddr == rsc_pkg::OFF_OFFA) begin
        s_d.set.offa = wv[7:0];
      end else if (s_q.awaddr == rsc_pkg::OFF_OFFB) begin
        s_d.set.offb = wv[7:0];
      end else if (s_q.awaddr == rsc_pkg::OFF_GTBL) begin
        tbl_we = (s_q.wstrb == 4'hF);
      end else if (s_q.awaddr == rsc_pkg::OFF_CMD) begin
        case (opc)
          rsc_pkg::CMD_NOP: begin
          end
          rsc_pkg::CMD_INIT: begin
            s_d.fsm = rsc_pkg::ST_BOOT;
          end
          rsc_pkg::CMD_SAVE: begin
            save_en = 1'b1;
          end
          rsc_pkg::CMD_DEL_ERR: begin
            del = (s_q.errs != '0);
          end
          rsc_pkg::CMD_TEMP: begin
            s_d.temp_start = !temp_busy;
          end
          rsc_pkg::CMD_INC_QGAIN: begin
            s_d.set.qgain = step8(s_q.set.qgain, 1'b1);
            inc_qg = 1'b1;
          end
          rsc_pkg::CMD_DEC_QGAIN: s_d.set.qgain = step8(s_q.set.qgain, 1'b0);
          rsc_pkg::CMD_INC_PHASE: s_d.set.phase = step8(s_q.set.phase, 1'b1);
          rsc_pkg::CMD_DEC_PHASE: s_d.set.phase = step8(s_q.set.phase, 1'b0);
          rsc_pkg::CMD_INC_OFFA: s_d.set.offa = step8(s_q.set.offa, 1'b1);
          rsc_pkg::CMD_DEC_OFFA: s_d.set.offa = step8(s_q.set.offa, 1'b0);
          rsc_pkg::CMD_INC_OFFB: s_d.set.offb = step8(s_q.set.offb, 1'b1);
          rsc_pkg::CMD_DEC_OFFB: s_d.set.offb = step8(s_q.set.offb, 1'b0);
          default: begin
            s_d.bresp = rsc_pkg::RESP_SLVERR;
            raise_bad = 1'b1;
          end
        endcase
      end
    end
    // new errors and a delete in one cycle net out, so no event is lost
    e_sum = {1'b0, s_q.errs} + (rsc_pkg::ERR_W+1)'(err_raise) + (rsc_pkg::ERR_W+1)'(raise_bad);
    if (del) e_sum = e_sum - 1'b1;
    s_d.errs = e_sum[rsc_pkg::ERR_W] ? '1 : e_sum[rsc_pkg::ERR_W-1:0];
    if (temp_done) s_d.temp = temp_val;
    s_d.tw_cnt = temp_busy ? s_q.tw_cnt + 16'h0001 : 16'h0000;
    if (!s_q.debug) begin
      s_d.blink_cnt = '0;
      s_d.blink = 1'b0;
    end else if (s_q.blink_cnt == rsc_pkg::BLINK_W'(BLINK_CYC - 1)) begin
      s_d.blink_cnt = '0;
      s_d.blink = !s_q.blink;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // outputs
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign amp_stage = s_q.set.amp;
  assign agc_level_code = s_q.set.agc;
  assign phase_code = s_q.set.phase;
  assign qgain_code = s_q.set.qgain;
  assign offset_a = s_q.set.offa;
  assign offset_b = s_q.set.offb;
  assign ctrl_shutdown = shutdown;
  assign osc_stop = shutdown;
  // error wins over blink; halted by pulse shows both lit
  assign led_red = (s_q.errs != '0) || (s_q.debug ? s_q.blink : (s_q.fsm == rsc_pkg::ST_HALT));
  assign led_green = (s_q.errs == '0);

  // =====================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_amp_direct: assert property (amp_wr_ok |=> amp_stage == $past(wv[9:0]))
    else $error("stage word not taken from low ten bits");
  a_stage_order: assert property (amp_wr_ok |=> amp_stage.rf_stage_minus12 == $past(wv[0])
      && amp_stage.if_stage_minus4 == $past(wv[4]) && amp_stage.second_stage_twenty == $past(wv[9]))
    else $error("stage bit order wrong");
  a_pulse_shut: assert property (s_q.pulse_s && !s_q.debug |-> ctrl_shutdown && osc_stop)
    else $error("pulse did not shut controller down");
  a_debug_blank: assert property (s_q.debug |-> !ctrl_shutdown && !osc_stop ##1 s_q.fsm != rsc_pkg::ST_HALT)
    else $error("pulse reset not suppressed in debug");
  a_red_blink: assert property (s_q.debug && s_q.errs == '0 |-> led_red == s_q.blink && led_green)
    else $error("red indicator not blinking in debug");
  a_lock_refuse: assert property (wr_fire && cur[32] && s_q.fsm == rsc_pkg::ST_RUN && s_q.errs != '0 && !is_del
      |=> s_q.bvalid && s_q.bresp == rsc_pkg::RESP_SLVERR && s_q.set == $past(s_q.set))
    else $error("command taken while error pending");
  a_one_delete: assert property (del && !err_raise |=> s_q.errs == $past(s_q.errs) - 1'b1)
    else $error("delete did not clear exactly one error");
  a_boot_load: assert property (s_q.fsm == rsc_pkg::ST_BOOT |=> s_q.set == $past(dflt_set))
    else $error("defaults not reloaded");
  a_save_store: assert property (save_en |=> dflt_set == $past(s_q.set))
    else $error("save did not store settings");
  a_inc_one: assert property (inc_qg && s_q.set.qgain != 8'hFF |=> qgain_code == $past(s_q.set.qgain) + 8'h01)
    else $error("increment not one code");
  a_gain_apply: assert property (gain_wr_ok |=> agc_level_code == $past(tbl_ent[7:0])
      && s_q.set.gain >= rsc_pkg::GAIN_MIN && s_q.set.gain <= rsc_pkg::GAIN_MAX)
    else $error("gain step entry not applied");
  a_temp_once: assert property (s_q.temp_start |=> temp_busy)
    else $error("temperature conversion did not start");
  a_temp_bound: assert property (temp_busy && s_q.tw_cnt == 16'(TEMP_CYC - 1) |=> temp_done && !temp_busy)
    else $error("temperature conversion did not finish in time");
  a_err_leds: assert property (s_q.errs != '0 |-> led_red && !led_green)
    else $error("error indicators wrong");

  c_err_cleared: cover property (s_q.errs != '0 ##1 s_q.errs == '0);
  c_debug_enter: cover property ($rose(s_q.debug));
  c_gain_write: cover property (gain_wr_ok);
  c_temp_read: cover property (temp_done);
endmodule : rsc_ctrl

// ===== rsc_ctrl_tb.sv
`timescale 1ns/1ps
// ========================================
// directed register-bus tests
module rsc_ctrl_tb;
  logic clk, rst_n, acquisition_pulse_input, err_raise, ctrl_shutdown, osc_stop, led_red, led_green, v;
  logic [7:0] s_axi_awaddr, s_axi_araddr, agc_level_code, phase_code, qgain_code, offset_a, offset_b;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [9:0] adc_in;
  rsc_pkg::rsc_amp_s amp_stage;
  logic [7:0] regs [4] = '{8'h18, 8'h14, 8'h1C, 8'h20};
  int fails = 0, total_checks = 0, cyc = 0;
  rsc_ctrl #(.BLINK_CYC(4), .TEMP_CYC(5)) i_dut (.*);
  rsc_host_model i_host (.*);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
    i_host.wr(a, x, r);
    chk("bresp", 32'(e), 32'(r));
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    i_host.rd(a, d, r);
    chk("rdata", e, d);
  endtask : rdc
  // outputs are looked at mid-cycle, clear of the flops' update
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : idle
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    {rst_n, acquisition_pulse_input, err_raise} = 3'h0;
    adc_in = 10'h2A5;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    idle(3);
    rdc(rsc_pkg::OFF_OFFA, 32'(rsc_pkg::NV_DFLT.offa));
    i_host.rd(8'h30, d, r);
    chk("unmapped", 32'(rsc_pkg::RESP_DECERR), 32'(r));
    wr(8'h08, 32'hFFFF_F641, rsc_pkg::RESP_OKAY);
    idle(1);
    chk("amp", 32'h241, 32'(amp_stage));
    for (int i = 0; i < 4; i++) begin
      wr(regs[i], 32'hFF, rsc_pkg::RESP_OKAY);
      wr(8'h04, 32'(6 + 2 * i), rsc_pkg::RESP_OKAY);
      rdc(regs[i], 32'hFE);
      wr(8'h04, 32'(5 + 2 * i), rsc_pkg::RESP_OKAY);
      rdc(regs[i], 32'hFF);
    end
    wr(8'h0C, 32'h3C, rsc_pkg::RESP_OKAY);
    idle(1);
    chk("agc", 32'h3C, 32'(agc_level_code));
    chk("qgain", 32'hFF, 32'(qgain_code));
    chk("phase", 32'hFF, 32'(phase_code));
    $display("test settings done");
    wr(8'h2C, 32'h0201_5521, rsc_pkg::RESP_OKAY);
    wr(8'h10, 32'h4, rsc_pkg::RESP_OKAY);
    idle(1);
    chk("amp", 32'h155, 32'(amp_stage));
    chk("agc", 32'h21, 32'(agc_level_code));
    wr(8'h10, 32'hB505, rsc_pkg::RESP_OKAY);
    wr(8'h10, 32'hB506, rsc_pkg::RESP_SLVERR);
    err_raise <= 1'b1;
    @(posedge clk);
    err_raise <= 1'b0;
    idle(1);
    chk("leds", 32'h2, 32'({led_red, led_green}));
    wr(8'h08, 32'h0, rsc_pkg::RESP_SLVERR);
    wr(8'h04, 32'h3, rsc_pkg::RESP_OKAY);
    i_host.rd(8'h24, d, r);
    chk("errors", 32'h1, 32'(d[3:0]));
    wr(8'h04, 32'h3, rsc_pkg::RESP_OKAY);
    wr(8'h08, 32'h0, rsc_pkg::RESP_OKAY);
    wr(8'h04, 32'hD, rsc_pkg::RESP_SLVERR);
    wr(8'h04, 32'h3, rsc_pkg::RESP_OKAY);
    $display("test errors done");
    wr(8'h20, 32'h5A, rsc_pkg::RESP_OKAY);
    wr(8'h04, 32'h2, rsc_pkg::RESP_OKAY);
    wr(8'h20, 32'h11, rsc_pkg::RESP_OKAY);
    wr(8'h04, 32'h1, rsc_pkg::RESP_OKAY);
    idle(3);
    chk("offb", 32'h5A, 32'(offset_b));
    chk("offa", 32'hFF, 32'(offset_a));
    wr(8'h04, 32'h4, rsc_pkg::RESP_OKAY);
    idle(12);
    rdc(8'h28, 32'h2A5);
    $display("test store done");
    acquisition_pulse_input <= 1'b1;
    idle(4);
    chk("halt", 32'h3, 32'({ctrl_shutdown, osc_stop}));
    @(posedge clk) acquisition_pulse_input <= 1'b0;
    idle(6);
    wr(8'h00, 32'h1, rsc_pkg::RESP_OKAY);
    acquisition_pulse_input <= 1'b1;
    idle(4);
    chk("halt", 32'h0, 32'({ctrl_shutdown, osc_stop}));
    v = led_red;
    idle(4);
    chk("blink", 32'(!v), 32'(led_red));
    wr(8'h00, 32'h0, rsc_pkg::RESP_OKAY);
    idle(4);
    chk("halt", 32'h3, 32'({ctrl_shutdown, osc_stop}));
    @(posedge clk) acquisition_pulse_input <= 1'b0;
    $display("test pulse done");
    complete_run();
  end
endmodule : rsc_ctrl_tb

// ===== rsc_host_model.sv
`timescale 1ns/1ps
// ========================================
// host bus master: one write or read at a time
module rsc_host_model (
  input logic clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic ta, tw, got;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
  end
  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    got = 1'b0;
    while (!got) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    got = 1'b0;
    while (!got) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      got = s_axi_rvalid;
      x = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rsc_host_model

// ===== rsc_nv_store.sv
`timescale 1ns/1ps
module rsc_nv_store #(
  parameter int unsigned STEPS = rsc_pkg::GT_STEPS
) (
  input logic clk,
  input logic save_en,
  input rsc_pkg::rsc_set_s save_set,
  input logic tbl_we,
  input logic [rsc_pkg::GT_IDX_W-1:0] tbl_wr_idx,
  input logic [rsc_pkg::GT_ENT_W-1:0] tbl_wr_ent,
  input logic [rsc_pkg::GT_IDX_W-1:0] tbl_rd_idx,
  output rsc_pkg::rsc_set_s dflt_set,
  output logic [rsc_pkg::GT_ENT_W-1:0] tbl_rd_ent
);
  typedef struct packed {
    rsc_pkg::rsc_set_s dflt;
  } rsc_nv_s;
  // no reset: contents model storage that survives resets
  rsc_nv_s s_q = '{dflt: rsc_pkg::NV_DFLT};
  rsc_nv_s s_d;
  logic [rsc_pkg::GT_ENT_W-1:0] tbl_q [STEPS] = '{default: rsc_pkg::GT_DFLT};

  always_comb begin
    s_d = s_q;
    if (save_en) begin
      s_d.dflt = save_set;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
    if (tbl_we) begin
      tbl_q[tbl_wr_idx] <= tbl_wr_ent;
    end
  end

  assign dflt_set = s_q.dflt;
  assign tbl_rd_ent = tbl_q[tbl_rd_idx];
endmodule : rsc_nv_store

// ===== rsc_pkg.sv
// Notes on behaviour
// - amplifier word is 10 bits; each bit drives one stage enable directly.
// - bits 0..3 drive rf stages minus12, zero, plus12, plus24.
// - bits 4..7 drive if stages minus4, eight, twenty, thirtytwo.
// - bits 8..9 drive second stages eight and twenty; clear bit means off.
// - normally an active acquisition pulse holds the controller shut down.
// - debug blanking suppresses pulse reset and oscillator stop; leaving restores both.
// - red indicator blinks while pulse blanking is enabled and no error is pending.
// - commands other than delete are refused while any error is unacknowledged.
// - each delete command clears exactly one pending error.
// - init reloads every setting from storage, as after power-up.
// - save writes all current settings to storage as new defaults.
// - after power-up or reset the stored defaults are applied.
// - channel offsets are readable and writable, unsigned 0 to 255.
// - increment and decrement change the chosen code by exactly one, holding at 0 and 255.
// - offsets reload with the stored value, never its complement.
// - agc write drives the agc converter directly, overriding gain.
// - gain table holds stage word and agc code per step; gain applies it.
// - gain is read and written, accepted from 1 to 46341.
// - temperature command runs one conversion and returns the reading.
// - a raised error lights red steadily and turns green off.
package rsc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_AMP = 8'h08;
  localparam logic [7:0] OFF_AGC = 8'h0C;
  localparam logic [7:0] OFF_GAIN = 8'h10;
  localparam logic [7:0] OFF_PHASE = 8'h14;
  localparam logic [7:0] OFF_QGAIN = 8'h18;
  localparam logic [7:0] OFF_OFFA = 8'h1C;
  localparam logic [7:0] OFF_OFFB = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_TEMP = 8'h28;
  localparam logic [7:0] OFF_GTBL = 8'h2C;
  localparam int unsigned CTRL_DEBUG_BIT = 0;
  localparam int unsigned ST_DEBUG_BIT = 4;
  localparam int unsigned ST_BUSY_BIT = 5;
  localparam int unsigned ST_HALT_BIT = 6;
  localparam int unsigned ST_STEP_LSB = 8;
  localparam int unsigned GT_IDX_LSB = 24;
  localparam int unsigned ERR_W = 4;
  localparam int unsigned ADC_W = 10;
  localparam int unsigned GT_STEPS = 16;
  localparam int unsigned GT_IDX_W = 4;
  localparam int unsigned GT_ENT_W = 18;
  localparam logic [15:0] GAIN_MIN = 16'h0001;
  localparam logic [15:0] GAIN_MAX = 16'hB505;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned BLINK_W = 26;
  localparam int unsigned TEMP_US = 10;
  localparam int unsigned TEMP_CYC = CLK_HZ / 1_000_000 * TEMP_US;
  typedef struct packed {
    logic second_stage_twenty;
    logic second_stage_eight;
    logic if_stage_thirtytwo;
    logic if_stage_twenty;
    logic if_stage_eight;
    logic if_stage_minus4;
    logic rf_stage_plus24;
    logic rf_stage_plus12;
    logic rf_stage_zero;
    logic rf_stage_minus12;
  } rsc_amp_s;
  typedef struct packed {
    rsc_amp_s amp;
    logic [7:0] agc;
    logic [15:0] gain;
    logic [7:0] phase;
    logic [7:0] qgain;
    logic [7:0] offa;
    logic [7:0] offb;
  } rsc_set_s;
  localparam rsc_set_s NV_DFLT = {10'h000, 8'h80, 16'h0001, 8'h80, 8'h80, 8'h80, 8'h80};
  localparam logic [GT_ENT_W-1:0] GT_DFLT = 18'h00080;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_INIT = 4'h1, CMD_SAVE = 4'h2, CMD_DEL_ERR = 4'h3,
    CMD_TEMP = 4'h4, CMD_INC_QGAIN = 4'h5, CMD_DEC_QGAIN = 4'h6, CMD_INC_PHASE = 4'h7,
    CMD_DEC_PHASE = 4'h8, CMD_INC_OFFA = 4'h9, CMD_DEC_OFFA = 4'hA, CMD_INC_OFFB = 4'hB,
    CMD_DEC_OFFB = 4'hC
  } rsc_cmd_e;
  typedef enum logic [1:0] {ST_BOOT = 2'b00, ST_RUN = 2'b01, ST_HALT = 2'b10} rsc_fsm_e;
  // gain step is the position of the highest set bit
  function automatic logic [GT_IDX_W-1:0] gain_step(input logic [15:0] g);
    logic [GT_IDX_W-1:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (g[i]) r = GT_IDX_W'(i);
    end
    return r;
  endfunction : gain_step
endpackage : rsc_pkg

// ===== rsc_temp_conv.sv
`timescale 1ns/1ps
module rsc_temp_conv #(
  parameter int unsigned CONV_CYC = rsc_pkg::TEMP_CYC
) (
  input logic clk,
  input logic rst_n,
  input logic start,
  input logic [rsc_pkg::ADC_W-1:0] adc_in,
  output logic busy,
  output logic done,
  output logic [rsc_pkg::ADC_W-1:0] value
);
  localparam int unsigned CNT_W = $clog2(CONV_CYC + 1);
  typedef struct packed {
    logic [rsc_pkg::ADC_W-1:0] meta;
    logic [rsc_pkg::ADC_W-1:0] sync;
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
    logic [rsc_pkg::ADC_W-1:0] val;
  } rsc_tc_s;
  rsc_tc_s s_q;
  rsc_tc_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = adc_in;
    s_d.sync = s_q.meta;
    s_d.done = 1'b0;
    if (s_q.busy) begin
      // sample only at the end so the level has settled
      if (s_q.cnt == CNT_W'(CONV_CYC - 1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.val = s_q.sync;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end else if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
  assign value = s_q.val;
endmodule : rsc_temp_conv
